/* osd_top.sv */
// Top of the octal serial I/O decoder: host decode, interrupt routing, APB registers
//
// The address map and register access over APB were left to the implementer.
`default_nettype none
`include "osd_params.svh"

module osd_top
(
    input  wire logic        MCLK_IN,            // 200 MHz clock
    input  wire logic        RESETN_IN,          // Asynchronous reset, active low
    // APB register port
    input  wire logic        PSEL_IN,            // Slave select
    input  wire logic        PENABLE_IN,         // Access phase
    input  wire logic        PWRITE_IN,          // Write when high
    input  wire logic [7:0]  PADDR_IN,           // Byte address
    input  wire logic [31:0] PWDATA_IN,          // Write data
    output var  logic        PREADY_OUT,         // Transfer done
    output var  logic [31:0] PRDATA_OUT,         // Read data
    output var  logic        PSLVERR_OUT,        // Unmapped address
    // Host expansion bus
    input  wire logic [9:0]  SA_IN,              // Address bits 9 to 0
    input  wire logic        IOR_N_IN,           // I/O read, active low
    input  wire logic        IOW_N_IN,           // I/O write, active low
    input  wire logic        AEN_IN,             // DMA cycle when high
    input  wire logic        WIDE_BUS_IN,        // Wide connector present
    output var  logic        ZWS_N_O_OUT,        // Zero-wait level, always low
    output var  logic        ZWS_N_OE_OUT,       // Zero-wait pull-down enable
    output var  logic [9:0]  IRQ_O_OUT,          // Host interrupt levels
    output var  logic [9:0]  IRQ_OE_OUT,         // Host interrupt enables
    // Quad UART chips
    input  wire logic [1:0]  CHIP_IRQ_IN,        // Interrupt of each chip
    output var  logic [7:0]  CHAN_CS_N_OUT,      // Channel selects, active low
    // Register interrupt
    output var  logic        INT_OUT             // High while unmasked event set
);

    // ****************************************************************
    // State and decoder
    // ****************************************************************
    osd_pkg::osd_state_s st_q;   // Registered state
    osd_pkg::osd_state_s st_d;   // Next state
    osd_dec_if           dec (); // Decoder carrier

    logic        io_cycle;   // Valid non-DMA I/O cycle
    logic        hit;        // Board selected this cycle
    logic        apb_done;   // Access phase completes at this edge
    logic [3:0]  events;     // Event pulses for status
    logic [31:0] rd_word;    // Read mux result
    logic        rd_ok;      // Address is mapped

    // Decoder sees the live address and the current settings
    assign dec.addr = SA_IN;
    assign dec.cfg  = st_q.cfg;

    osd_decode u_decode
    (
        .dec (dec)
    );

    // ****************************************************************
    // Line permission
    // ****************************************************************
    // Narrow-bus lines are IRQ3, 4, 5, 7, 9; the rest need the wide connector
    function automatic logic line_ok(input logic [3:0] sel, input logic wide);
        line_ok = (sel < `OSD_NARROW_LINES) ||
                  (wide && (sel < 4'(`OSD_NUM_LINES)));
    endfunction

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (PADDR_IN)
            `OSD_REG_CONFIG:
            begin
                rd_word[5:0]  = st_q.cfg.base_address_links;
                rd_word[11:8] = st_q.cfg.com_relocate_links;
                rd_word[12]   = st_q.cfg.upper_disable;
                rd_word[13]   = st_q.cfg.irq_merge;
                rd_word[14]   = st_q.cfg.zero_wait_option;
            end
            `OSD_REG_ROUTE:
            begin
                rd_word[3:0]  = st_q.cfg.sel_a;
                rd_word[4]    = st_q.cfg.en_a;
                rd_word[11:8] = st_q.cfg.sel_b;
                rd_word[12]   = st_q.cfg.en_b;
            end
            `OSD_REG_STATUS:
            begin
                rd_word[3:0] = st_q.status;
            end
            `OSD_REG_MASK:
            begin
                rd_word[3:0] = st_q.mask;
            end
            `OSD_REG_STATE:
            begin
                // Live view of selects, chip interrupts and bus width
                rd_word[7:0] = ~st_q.cs_n;
                rd_word[9:8] = CHIP_IRQ_IN;
                rd_word[10]  = WIDE_BUS_IN;
            end
            default:
            begin
                // Unmapped: zero data and an error answer
                rd_ok = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;

        // Byte-wide I/O strobe without DMA; the bus width does not matter here
        io_cycle = (~IOR_N_IN || ~IOW_N_IN) && ~AEN_IN;
        hit      = io_cycle && (|dec.chan_sel);

        // Channel selects follow the decoded address
        st_d.cs_n = io_cycle ? ~dec.chan_sel : 8'hff;

        // Pull zero-wait low with the channel select when the option is set and a strobed cycle hits
        st_d.zws_oe = hit && st_q.cfg.zero_wait_option;

        // Interrupt routing per host line
        for (int i = 0; i < `OSD_NUM_LINES; i++)
        begin
            st_d.irq_o[i]  = 1'b0;
            st_d.irq_oe[i] = 1'b0;
            if (st_q.cfg.en_a && (st_q.cfg.sel_a == 4'(i)) && line_ok(st_q.cfg.sel_a, WIDE_BUS_IN))
            begin
                st_d.irq_oe[i] = 1'b1;
                if (st_q.cfg.irq_merge)
                begin
                    // Side A carries both chips
                    st_d.irq_o[i] = CHIP_IRQ_IN[0] | CHIP_IRQ_IN[1];
                end
                else
                begin
                    st_d.irq_o[i] = CHIP_IRQ_IN[0];
                end
            end
            // Side B floats while merged, so one event never fires two lines
            if (st_q.cfg.en_b && ~st_q.cfg.irq_merge && (st_q.cfg.sel_b == 4'(i)) &&
                line_ok(st_q.cfg.sel_b, WIDE_BUS_IN))
            begin
                st_d.irq_oe[i] = 1'b1;
                st_d.irq_o[i]  = st_d.irq_o[i] | CHIP_IRQ_IN[1];
            end
        end

        // Event pulses: chip interrupt rises, overlap and board access starts
        st_d.chip_irq_prev = CHIP_IRQ_IN;
        st_d.hit_prev      = hit;
        events[`OSD_EV_CHIP0]    = CHIP_IRQ_IN[0] && ~st_q.chip_irq_prev[0];
        events[`OSD_EV_CHIP1]    = CHIP_IRQ_IN[1] && ~st_q.chip_irq_prev[1];
        events[`OSD_EV_CONFLICT] = io_cycle && dec.conflict && ~st_q.hit_prev;
        events[`OSD_EV_ACCESS]   = hit && ~st_q.hit_prev;

        // APB: one wait cycle, then the answer; effects only at completion
        apb_done     = PSEL_IN && PENABLE_IN && st_q.pready;
        st_d.pready  = PSEL_IN && PENABLE_IN && ~st_q.pready;
        st_d.prdata  = (PSEL_IN && PENABLE_IN && ~st_q.pready && ~PWRITE_IN) ? rd_word : 32'h0000_0000;
        st_d.pslverr = PSEL_IN && PENABLE_IN && ~st_q.pready && ~rd_ok;

        if (apb_done && PWRITE_IN)
        begin
            case (PADDR_IN)
                `OSD_REG_CONFIG:
                begin
                    st_d.cfg.base_address_links = PWDATA_IN[5:0];
                    st_d.cfg.com_relocate_links = PWDATA_IN[11:8];
                    st_d.cfg.upper_disable      = PWDATA_IN[12];
                    st_d.cfg.irq_merge          = PWDATA_IN[13];
                    st_d.cfg.zero_wait_option   = PWDATA_IN[14];
                end
                `OSD_REG_ROUTE:
                begin
                    st_d.cfg.sel_a = PWDATA_IN[3:0];
                    st_d.cfg.en_a  = PWDATA_IN[4];
                    st_d.cfg.sel_b = PWDATA_IN[11:8];
                    st_d.cfg.en_b  = PWDATA_IN[12];
                end
                `OSD_REG_MASK:
                begin
                    st_d.mask = PWDATA_IN[3:0];
                end
                default:
                begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end

        // A read clears only what it reported, so an event landing in the access phase survives
        if (apb_done && ~PWRITE_IN && (PADDR_IN == `OSD_REG_STATUS))
        begin
            st_d.status = (st_q.status & ~st_q.prdata[3:0]) | events;
        end
        else
        begin
            st_d.status = st_q.status | events;
        end

        st_d.int_line = |(st_d.status & st_d.mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge MCLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st_q                        <= '0;
            st_q.cfg.base_address_links <= `OSD_RST_BASE;
            st_q.cfg.com_relocate_links <= `OSD_RST_RELOC;
            st_q.cfg.sel_a              <= `OSD_RST_SEL_A;
            st_q.cfg.sel_b              <= `OSD_RST_SEL_B;
            st_q.mask                   <= `OSD_RST_MASK;
            st_q.cs_n                   <= 8'hff;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs, all but the constant zero-wait level straight from the state register
    // ****************************************************************
    assign PREADY_OUT    = st_q.pready;
    assign PRDATA_OUT    = st_q.prdata;
    assign PSLVERR_OUT   = st_q.pslverr;
    assign ZWS_N_O_OUT   = 1'b0;
    assign ZWS_N_OE_OUT  = st_q.zws_oe;
    assign IRQ_O_OUT     = st_q.irq_o;
    assign IRQ_OE_OUT    = st_q.irq_oe;
    assign CHAN_CS_N_OUT = st_q.cs_n;
    assign INT_OUT       = st_q.int_line;

endmodule // osd_top

`default_nettype wire

/* osd_params.svh */
// Constants of the octal serial I/O decoder: offsets, fields, reset values
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses on the register bus)
// ****************************************************************
`define OSD_REG_CONFIG   8'h00
`define OSD_REG_ROUTE    8'h04
`define OSD_REG_STATUS   8'h08
`define OSD_REG_MASK     8'h0c
`define OSD_REG_STATE    8'h10

// ****************************************************************
// Reset values
// ****************************************************************
// All base links fitted except the A8 one: group at 0x100
`define OSD_RST_BASE     6'h2f
`define OSD_RST_RELOC    4'h0
`define OSD_RST_SEL_A    4'h0
`define OSD_RST_SEL_B    4'h1
`define OSD_RST_MASK     4'h0

// ****************************************************************
// COM window addresses, bits 9 to 3
// ****************************************************************
`define OSD_COM1_WIN     7'h7f
`define OSD_COM2_WIN     7'h5f
`define OSD_COM3_WIN     7'h7d
`define OSD_COM4_WIN     7'h5d

// ****************************************************************
// Interrupt routing: ten choices, the first five on the narrow bus
// ****************************************************************
`define OSD_NUM_LINES    10
`define OSD_NARROW_LINES 4'h5

// ****************************************************************
// Status bit positions
// ****************************************************************
`define OSD_EV_CHIP0     0
`define OSD_EV_CHIP1     1
`define OSD_EV_CONFLICT  2
`define OSD_EV_ACCESS    3

`endif

/* osd_pkg.sv */
// Types shared by the octal serial I/O decoder modules
`default_nettype none

package osd_pkg;

    // ****************************************************************
    // Link settings held in software registers
    // ****************************************************************
    typedef struct packed {
        logic [5:0] base_address_links;  // Bit 5 is A9; 1 = link fitted
        logic [3:0] com_relocate_links;  // Channel n moved to COM n+1
        logic       upper_disable;       // Channels 4-7 not decoded
        logic       irq_merge;           // Both chips onto side A
        logic       zero_wait_option;    // Zero-wait-state cycles
        logic [3:0] sel_a;               // Line index for side A
        logic       en_a;                // Side A link fitted
        logic [3:0] sel_b;               // Line index for side B
        logic       en_b;                // Side B link fitted
    } osd_cfg_s;

    // ****************************************************************
    // Whole state of the top module
    // ****************************************************************
    typedef struct packed {
        osd_cfg_s    cfg;           // Link settings
        logic [3:0]  status;        // Sticky events
        logic [3:0]  mask;          // Event enables
        logic        pready;        // Access phase answer
        logic [31:0] prdata;        // Read data
        logic        pslverr;       // Unmapped address
        logic [7:0]  cs_n;          // Channel selects, active low
        logic        zws_oe;        // Zero-wait pull-down enable
        logic [9:0]  irq_o;         // Host interrupt levels
        logic [9:0]  irq_oe;        // Host interrupt enables
        logic        int_line;      // Register interrupt
        logic [1:0]  chip_irq_prev; // Edge detect of chip interrupts
        logic        hit_prev;      // Edge detect of board access
    } osd_state_s;

endpackage : osd_pkg

`default_nettype wire

/* osd_dec_if.sv */
// Carrier between the top module and the address decoder
`default_nettype none

interface osd_dec_if;
    logic [9:0]       addr;     // Host address bits 9 to 0
    osd_pkg::osd_cfg_s cfg;     // Link settings
    logic [7:0]       chan_sel; // One-hot channel hit
    logic             conflict; // Group and COM window overlap

    // Decoder side
    modport decoder (input addr, input cfg, output chan_sel, output conflict);
    // User side
    modport user (output addr, output cfg, input chan_sel, input conflict);
endinterface : osd_dec_if

`default_nettype wire

/* osd_decode.sv */
// Address decoder: group of channels and COM windows
`default_nettype none
`include "osd_params.svh"
module osd_decode
(
    osd_dec_if.decoder dec
);

    // ****************************************************************
    // COM window of a relocated channel
    // ****************************************************************
    function automatic logic [6:0] com_window(input logic [1:0] idx);
        case (idx)
            2'h0:    com_window = `OSD_COM1_WIN;
            2'h1:    com_window = `OSD_COM2_WIN;
            2'h2:    com_window = `OSD_COM3_WIN;
            default: com_window = `OSD_COM4_WIN;
        endcase
    endfunction

    logic [6:0] base_unit;  // Base in eight-byte units
    logic [6:0] rel;        // Offset from base in eight-byte units
    logic [3:0] slot;       // Next free group slot
    logic       present;    // Channel sits in the group
    logic [7:0] group_sel;  // Group hit
    logic [3:0] com_sel;    // COM window hits

    // ****************************************************************
    // Decode: group slots fill in channel order, relocated ones skipped
    // ****************************************************************
    always_comb
    begin
        // Fitted link demands a zero, open link a one
        base_unit = {~dec.cfg.base_address_links, 1'b0};
        // Below the base wraps to a large offset and misses
        rel       = dec.addr[9:3] - base_unit;
        slot      = 4'h0;
        group_sel = 8'h00;
        com_sel   = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < 4)
            begin
                present = ~dec.cfg.com_relocate_links[i];
                com_sel[i] = dec.cfg.com_relocate_links[i] &&
                             (dec.addr[9:3] == com_window(2'(i)));
            end
            else
            begin
                present = ~dec.cfg.upper_disable;
            end
            if (present)
            begin
                if (rel == {3'h0, slot})
                begin
                    group_sel[i] = 1'b1;
                end
                slot = slot + 4'h1;
            end
        end
        // On overlap the group wins over a COM window
        if (|group_sel)
        begin
            dec.chan_sel = group_sel;
        end
        else
        begin
            dec.chan_sel = {4'h0, com_sel};
        end
        dec.conflict = (|group_sel) && (|com_sel);
    end

endmodule // osd_decode

`default_nettype wire

/* osd_monitor.sv */
// Port checker of the octal serial I/O decoder, bound onto the top module
`default_nettype none

module osd_monitor
(
    input wire logic        MCLK_IN,
    input wire logic        RESETN_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        IOR_N_IN,
    input wire logic        IOW_N_IN,
    input wire logic        AEN_IN,
    input wire logic        WIDE_BUS_IN,
    input wire logic        PREADY_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        ZWS_N_O_OUT,
    input wire logic        ZWS_N_OE_OUT,
    input wire logic [9:0]  IRQ_OE_OUT,
    input wire logic [7:0]  CHAN_CS_N_OUT
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Checks on the host decode and the register port
    // ****************************************************************
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);

    AST_DMA_BLOCK:
        assert property (AEN_IN |=> CHAN_CS_N_OUT == 8'hff) else $error("Select during DMA cycle");
    AST_IDLE_DESELECT:
        assert property (IOR_N_IN && IOW_N_IN |=> CHAN_CS_N_OUT == 8'hff) else $error("Select without strobe");
    AST_ONE_CHANNEL:
        assert property ($onehot0(~CHAN_CS_N_OUT)) else $error("Several channels selected");
    AST_ZWS_NEEDS_HIT:
        assert property (ZWS_N_OE_OUT |-> CHAN_CS_N_OUT != 8'hff) else $error("Zero wait without decode");
    AST_ZWS_IDLE:
        assert property (IOR_N_IN && IOW_N_IN |=> !ZWS_N_OE_OUT) else $error("Zero wait without strobe");
    AST_ZWS_LEVEL:
        assert property (ZWS_N_O_OUT == 1'b0) else $error("Zero wait level not low");
    AST_NARROW_LINES:
        assert property (!WIDE_BUS_IN |=> IRQ_OE_OUT[9:5] == 5'h00) else $error("Upper line driven on narrow bus");
    AST_READY_WAIT:
        assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT) else $error("Ready late");
    AST_READY_PULSE:
        assert property (PREADY_OUT |=> !PREADY_OUT) else $error("Ready longer than one cycle");
    AST_ERR_WITH_READY:
        assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("Error without ready");
    AST_DATA_IDLE:
        assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("Read data outside answer");

    // Main scenarios seen
    COV_ZWS: cover property (ZWS_N_OE_OUT);
    COV_ERR: cover property (PSLVERR_OUT);
    COV_WIDE: cover property (IRQ_OE_OUT[9:5] != 5'h00);
endmodule // osd_monitor

bind osd_top osd_monitor osd_monitor_i (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .IOR_N_IN(IOR_N_IN), .IOW_N_IN(IOW_N_IN), .AEN_IN(AEN_IN),
    .WIDE_BUS_IN(WIDE_BUS_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .ZWS_N_O_OUT(ZWS_N_O_OUT), .ZWS_N_OE_OUT(ZWS_N_OE_OUT), .IRQ_OE_OUT(IRQ_OE_OUT),
    .CHAN_CS_N_OUT(CHAN_CS_N_OUT));

`default_nettype wire

/* osd_host_model.sv */
// Host CPU model: byte-wide I/O cycles and its view of the interrupt lines
`default_nettype none

module osd_host_model
(
    input  wire logic       clk_in,       // Bench clock
    input  wire logic [9:0] irq_o_in,     // Levels from the board
    input  wire logic [9:0] irq_oe_in,    // Drive enables from the board
    output var  logic [9:0] sa_out,       // Address bits 9 to 0
    output var  logic       ior_n_out,    // Read strobe, active low
    output var  logic       iow_n_out,    // Write strobe, active low
    output var  logic       aen_out,      // DMA marker
    output var  logic [9:0] irq_wire_out  // Resolved line levels
);
    timeunit 1ns;
    timeprecision 1ps;

    // Undriven lines read as pulled low, so a stale level never passes
    assign irq_wire_out = irq_o_in & irq_oe_in;

    initial
    begin
        sa_out    = 10'h000;
        ior_n_out = 1'b1;
        iow_n_out = 1'b1;
        aen_out   = 1'b0;
    end

    // Address settles a cycle before the byte-wide strobe falls
    task automatic io_start(input logic [9:0] a, input logic wr, input logic dma);
        @(posedge clk_in);
        sa_out  <= a;
        aen_out <= dma;
        @(posedge clk_in);
        ior_n_out <= wr;
        iow_n_out <= !wr;
    endtask

    // Strobe ends, then the address is no longer held
    task automatic io_end();
        @(posedge clk_in);
        ior_n_out <= 1'b1;
        iow_n_out <= 1'b1;
        @(posedge clk_in);
        sa_out  <= ~sa_out;
        aen_out <= 1'b0;
    endtask
endmodule // osd_host_model

`default_nettype wire

/* tb_octal_serial_io_decode.sv */
// Self-checking testbench of the octal serial I/O decoder
`default_nettype none

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end

module tb_octal_serial_io_decode;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [6:0] WIN [4] = '{7'h7f, 7'h5f, 7'h7d, 7'h5d};  // COM windows
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ior_n, iow_n, aen, wide, zws_o, zws_oe, intr;
    logic [7:0]  paddr, cs_n, es;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  sa, irq_o, irq_oe, irq_wire, ad;
    logic [1:0]  chip;
    logic [14:0] cfg;  // Config word under test
    logic [12:0] rt;   // Route word under test
    logic        er, m, dma;
    int          miscompares, checks_done;

    osd_top osd_top_i (.MCLK_IN(mclk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
        .PSLVERR_OUT(pslverr), .SA_IN(sa), .IOR_N_IN(ior_n), .IOW_N_IN(iow_n), .AEN_IN(aen),
        .WIDE_BUS_IN(wide), .ZWS_N_O_OUT(zws_o), .ZWS_N_OE_OUT(zws_oe), .IRQ_O_OUT(irq_o),
        .IRQ_OE_OUT(irq_oe), .CHIP_IRQ_IN(chip), .CHAN_CS_N_OUT(cs_n), .INT_OUT(intr));

    osd_host_model osd_host_model_i (.clk_in(mclk), .irq_o_in(irq_o), .irq_oe_in(irq_oe), .sa_out(sa),
        .ior_n_out(ior_n), .iow_n_out(iow_n), .aen_out(aen), .irq_wire_out(irq_wire));

    always #2.5 mclk = ~mclk;

    // ****************************************************************
    // Expectations and bus tasks
    // ****************************************************************
    // Present channels pack from the base; group beats a COM window
    function automatic logic [7:0] exp_sel(logic [9:0] a, logic [14:0] c);
        logic [6:0] u;
        logic [7:0] s;
        int k;
        s = 8'h00;
        k = 0;
        u = a[9:3] - {~c[5:0], 1'b0};
        for (int ch = 0; ch < 8; ch++)
            if (ch < 4 ? !c[8 + ch] : !c[12])
            begin
                if (u == 7'(k)) s[ch] = 1'b1;
                k++;
            end
        if (s == 8'h00)
            for (int n = 0; n < 4; n++)
                if (c[8 + n] && a[9:3] == WIN[n]) s[n] = 1'b1;
        return s;
    endfunction

    // Line levels seen by the host; chips both high gives the enables
    function automatic logic [9:0] exp_irq(logic [12:0] r, logic mg, logic w, logic [1:0] c);
        logic [9:0] v;
        v = 10'h000;
        for (int i = 0; i < 10; i++)
            if (i < 5 || w)
            begin
                if (r[4] && r[3:0] == 4'(i)) v[i] = v[i] | c[0] | (mg & c[1]);
                if (r[12] && !mg && r[11:8] == 4'(i)) v[i] = v[i] | c[1];
            end
        return v;
    endfunction

    // One APB transfer; the request is held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin miscompares++; $display("Error at %0t: no ready", $time); end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard: twenty thousand cycles
    initial
    begin
        #100000;
        miscompares++;
        finish_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {mclk, rstn, psel, penable, pwrite, wide} = 6'h00;
        {paddr, pwdata, chip} = 42'h0;
        miscompares = 0;
        checks_done = 0;
        rd = $urandom(45409);
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        // Reset values and an unmapped place
        apb(0, 8'h00, 32'h0); `CHK(rd, 32'h0000002f)
        apb(0, 8'h04, 32'h0); `CHK(rd, 32'h00000100)
        apb(0, 8'h0c, 32'h0); `CHK(rd, 32'h00000000)
        apb(0, 8'h14, 32'h0); `CHK({er, rd}, 33'h100000000)
        $display("Test registers done");
        // Decode: corners first, then random links, moves and addresses
        for (int i = 0; i < 60; i++)
        begin
            cfg = 15'($urandom) | 15'h0004;
            ad = {~cfg[5:0], 4'h0} + 10'($urandom % 64);
            if ($urandom % 3 == 0) ad = {WIN[$urandom % 4], 3'($urandom)};
            if (i < 10) cfg = (i < 8) ? 15'h002f : 15'h0f2f;
            if (i < 10) ad = (i < 8) ? 10'h100 + 10'(8 * i) : (i == 8) ? 10'h100 : 10'h120;
            if (i < 10) ad[2:0] = 3'($urandom);
            dma = (i >= 10) && ($urandom % 6 == 0);
            es = dma ? 8'h00 : exp_sel(ad, cfg);
            apb(1, 8'h00, {17'h0, cfg});
            osd_host_model_i.io_start(ad, 1'($urandom), dma);
            repeat (2) @(posedge mclk);
            #1;
            `CHK(cs_n, ~es)
            `CHK({zws_o, zws_oe}, {1'b0, cfg[14] && es != 8'h00})
            osd_host_model_i.io_end();
            #1;
            `CHK(cs_n, 8'hff)
        end
        $display("Test decode done");
        // Interrupt routing: walk side A over every line, then random
        for (int i = 0; i < 40; i++)
        begin
            m = (i < 10) ? 1'b0 : 1'($urandom);
            rt = (i < 10) ? {9'h001, 4'(i)} : 13'($urandom);
            apb(1, 8'h00, {18'h0, m, 13'h002f});
            wide <= (i < 10) ? 1'b1 : 1'($urandom);
            chip <= 2'($urandom);
            apb(1, 8'h04, {19'h0, rt});
            repeat (2) @(posedge mclk);
            #1;
            `CHK(irq_oe, exp_irq(rt, m, wide, 2'b11))
            `CHK(irq_wire, exp_irq(rt, m, wide, chip))
        end
        $display("Test routing done");
        // Events: raise, clear by read, mask, overlap of group and COM
        apb(1, 8'h0c, 32'h3);
        chip <= 2'b00;
        apb(0, 8'h08, 32'h0);
        @(posedge mclk);
        chip <= 2'b01;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(intr, 1'b1)
        apb(0, 8'h08, 32'h0); `CHK(rd, 32'h1)
        #1;
        `CHK(intr, 1'b0)
        apb(1, 8'h0c, 32'h0);
        chip <= 2'b11;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(intr, 1'b0)
        apb(0, 8'h08, 32'h0); `CHK(rd, 32'h2)
        apb(0, 8'h10, 32'h0); `CHK(rd, {21'h0, wide, 10'h300})
        apb(1, 8'h00, 32'h0403);
        osd_host_model_i.io_start(10'h3e8, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(cs_n, 8'hbf)
        osd_host_model_i.io_end();
        apb(0, 8'h08, 32'h0); `CHK(rd, 32'hc)
        $display("Test events done");
        finish_test();
    end
endmodule // tb_octal_serial_io_decode

`default_nettype wire
